/* hw/cbx_exec.sv */
// Decided for this implementation: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module cbx_exec (
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  input  wire logic [cbx_pkg::AV_AW-1:0]   avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [cbx_pkg::AV_DW-1:0]   avs_writedata,
  input  wire logic [cbx_pkg::AV_BEW-1:0]  avs_byteenable,
  output var  logic [cbx_pkg::AV_DW-1:0]   avs_readdata,
  output var  logic                        avs_waitrequest,
  output var  logic                        core_busy
);
  import cbx_pkg::*;

  cbx_state_e          state;
  logic [1:0]          qcnt;
  logic                q_tick;
  logic [1:0]          nop_cnt;
  logic                ext_en;
  logic [IR_W-1:0]     instr;
  logic [DATA_W-1:0]   wreg;
  logic [ST_W-1:0]     status;
  logic [BSR_W-1:0]    bank_select_reg;
  logic [PC_W-1:0]     pc;
  logic [DMEM_AW-1:0]  idx_base;
  logic [DMEM_AW-1:0]  opaddr;
  logic [DATA_W-1:0]   opnd;
  logic [DATA_W-1:0]   result;
  logic [ST_W-1:0]     flags_q;
  logic                br_take;
  logic                illegal;
  logic [DATA_W-1:0]   dmem [0:(1<<DMEM_AW)-1];
  logic [AV_DW-1:0]    rd_mux;
  logic [AV_DW-1:0]    wr_val;
  logic                wr_acc;
  logic                sw_mem_we;
  logic [DATA_W-1:0]   lit;
  logic                d_bit;
  logic                a_bit;
  logic [2:0]          bidx;
  logic                is_and_lit;
  logic                is_and_file;
  logic                is_add_c;
  logic                is_bit_clr;
  logic                is_br_cs;
  logic                is_br_cc;
  logic                is_br_ns;
  logic                is_br_nc;
  logic                is_br;
  logic                is_file;
  logic                br_cond;
  logic [PC_W-1:0]     off2;
  logic [DMEM_AW-1:0]  eff_addr;
  cbx_alu_e            alu_op;
  logic [DATA_W-1:0]   alu_res;
  logic [ST_W-1:0]     alu_flags;
  logic [ST_W-1:0]     st_mask;
  logic                fire_q1;
  logic                fire_q2;
  logic                fire_q3;
  logic                fire_q4;
  logic                core_w_we;
  logic                mem_we;

  function automatic logic [AV_DW-1:0] be_merge(input logic [AV_DW-1:0]  old_v,
                                                input logic [AV_DW-1:0]  new_v,
                                                input logic [AV_BEW-1:0] be);
    logic [AV_DW-1:0] m;
    m = old_v;
    for (int i = 0; i < AV_BEW; i++)
      if (be[i])
        m[8*i +: 8] = new_v[8*i +: 8];
    return m;
  endfunction : be_merge

  // decode
  assign lit         = instr[DATA_W-1:0];
  assign d_bit       = instr[IR_D];
  assign a_bit       = instr[IR_A];
  assign bidx        = instr[IR_B_LSB +: 3];
  assign is_and_lit  = instr[IR_W-1:OPC8_LSB] == OP_AND_LIT;
  assign is_and_file = instr[IR_W-1:OPC6_LSB] == OP_AND_FILE;
  assign is_add_c    = instr[IR_W-1:OPC6_LSB] == OP_ADD_C;
  assign is_bit_clr  = instr[IR_W-1:OPC4_LSB] == OP_BIT_CLR;
  assign is_br_cs    = instr[IR_W-1:OPC8_LSB] == OP_BR_CS;
  assign is_br_cc    = instr[IR_W-1:OPC8_LSB] == OP_BR_CC;
  assign is_br_ns    = instr[IR_W-1:OPC8_LSB] == OP_BR_NS;
  assign is_br_nc    = instr[IR_W-1:OPC8_LSB] == OP_BR_NC;
  assign is_br       = is_br_cs | is_br_cc | is_br_ns | is_br_nc;
  assign is_file     = is_and_file | is_add_c | is_bit_clr;
  assign off2        = {{12{lit[7]}}, lit, 1'b0};
  assign br_cond     = (is_br_cs &  status[ST_C])
                     | (is_br_cc & ~status[ST_C])
                     | (is_br_ns &  status[ST_N])
                     | (is_br_nc & ~status[ST_N]);
  assign alu_op      = is_add_c ? ALU_ADDC : (is_bit_clr ? ALU_BCLR : ALU_AND);
  assign st_mask     = is_add_c ? ST_MASK_ALL : ST_MASK_NZ;

  assign fire_q1   = q_tick && (state == S_Q1);
  assign fire_q2   = q_tick && (state == S_Q2);
  assign fire_q3   = q_tick && (state == S_Q3);
  assign fire_q4   = q_tick && (state == S_Q4);
  assign core_w_we = fire_q4 && (is_and_lit || ((is_and_file || is_add_c) && !d_bit));
  assign mem_we    = fire_q4 && (((is_and_file || is_add_c) && d_bit) || is_bit_clr);

  cbx_addr u_addr (
    .fadr     (lit),
    .a_bit    (a_bit),
    .ext_en   (ext_en),
    .bank_select_reg      (bank_select_reg),
    .idx_base (idx_base),
    .eff_addr (eff_addr)
  );

  cbx_alu u_alu (
    .op      (alu_op),
    .w       (wreg),
    .f       (opnd),
    .c       (status[ST_C]),
    .bit_idx (bidx),
    .res     (alu_res),
    .flags   (alu_flags)
  );

  // bus side
  assign wr_acc    = avs_write && !avs_waitrequest;
  assign wr_val    = be_merge(rd_mux, avs_writedata, avs_byteenable);
  assign sw_mem_we = wr_acc && avs_address[DMEM_SEL_BIT] && avs_byteenable[0];

  always_comb
  begin
    rd_mux = '0;
    if (avs_address[DMEM_SEL_BIT])
      rd_mux[DATA_W-1:0] = dmem[avs_address[DMEM_AW-1:0]];
    else
      case (avs_address)
        REG_CTRL:   rd_mux[CTRL_EXT] = ext_en;
        REG_INSTR:  rd_mux[IR_W-1:0] = instr;
        REG_WREG:   rd_mux[DATA_W-1:0] = wreg;
        REG_STATUS: rd_mux[ST_W-1:0] = status;
        REG_BANK:   rd_mux[BSR_W-1:0] = bank_select_reg;
        REG_PC:     rd_mux[PC_W-1:0] = pc;
        REG_IDX:    rd_mux[DMEM_AW-1:0] = idx_base;
        REG_CORE:
        begin
          rd_mux[CORE_BUSY]  = core_busy;
          rd_mux[CORE_TAKEN] = br_take;
          rd_mux[CORE_ILL]   = illegal;
        end
        default:    rd_mux = '0;
      endcase
  end

  // one wait state; writes stall while an instruction runs
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
    end
    else if (avs_waitrequest && (avs_read || (avs_write && !core_busy)))
    begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= avs_read ? rd_mux : '0;
    end
    else
      avs_waitrequest <= 1'b1;
  end

  // quarter-cycle enable
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      qcnt   <= 2'h0;
      q_tick <= 1'b0;
    end
    else if (qcnt == QDIV_LAST)
    begin
      qcnt   <= 2'h0;
      q_tick <= 1'b1;
    end
    else
    begin
      qcnt   <= qcnt + 2'h1;
      q_tick <= 1'b0;
    end
  end

  // quarter sequencer
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state     <= S_IDLE;
      core_busy <= 1'b0;
      nop_cnt   <= 2'h0;
    end
    else
    begin
      if (wr_acc && (avs_address == REG_INSTR))
        core_busy <= 1'b1;
      if (q_tick)
        unique case (state)
          S_IDLE: if (core_busy) state <= S_Q1;
          S_Q1:   state <= S_Q2;
          S_Q2:   state <= S_Q3;
          S_Q3:   state <= S_Q4;
          S_Q4:
            if (br_take)
            begin
              state   <= S_NOP;
              nop_cnt <= 2'h0;
            end
            else
            begin
              state     <= S_IDLE;
              core_busy <= 1'b0;
            end
          S_NOP:
            if (nop_cnt == NOP_LAST)
            begin
              state     <= S_IDLE;
              core_busy <= 1'b0;
            end
            else
              nop_cnt <= nop_cnt + 2'h1;
        endcase
    end
  end

  // operand path
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      opaddr  <= '0;
      opnd    <= '0;
      result  <= '0;
      flags_q <= '0;
      br_take <= 1'b0;
      illegal <= 1'b0;
    end
    else
    begin
      if (fire_q1)
        opaddr <= eff_addr;
      if (fire_q2)
        opnd <= is_file ? dmem[opaddr] : lit;
      if (fire_q3)
      begin
        result  <= alu_res;
        flags_q <= alu_flags;
        br_take <= is_br && br_cond;
        illegal <= !(is_file || is_and_lit || is_br);
      end
      else if (wr_acc && (avs_address == REG_INSTR))
        illegal <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      ext_en <= 1'b0;
    else if (wr_acc && (avs_address == REG_CTRL))
      ext_en <= wr_val[CTRL_EXT];
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      instr    <= IR_RST;
      bank_select_reg      <= BSR_RST;
      idx_base <= IDX_RST;
    end
    else if (wr_acc)
    begin
      if (avs_address == REG_INSTR)
        instr <= wr_val[IR_W-1:0];
      if (avs_address == REG_BANK)
        bank_select_reg <= wr_val[BSR_W-1:0];
      if (avs_address == REG_IDX)
        idx_base <= wr_val[DMEM_AW-1:0];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      wreg <= W_RST;
    else if (core_w_we)
      wreg <= result;
    else if (wr_acc && (avs_address == REG_WREG))
      wreg <= wr_val[DATA_W-1:0];
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      status <= ST_RST;
    else if (fire_q4 && (is_add_c || is_and_lit || is_and_file))
      status <= (status & ~st_mask) | (flags_q & st_mask);
    else if (wr_acc && (avs_address == REG_STATUS))
      status <= wr_val[ST_W-1:0];
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      pc <= PC_RST;
    else if (fire_q1)
      pc <= pc + PC_STEP;
    else if (fire_q4 && br_take)
      pc <= pc + off2;
    else if (wr_acc && (avs_address == REG_PC))
      pc <= {wr_val[PC_W-1:1], 1'b0};
  end

  always_ff @(posedge sys_clk)
  begin
    if (mem_we)
      dmem[opaddr] <= result;
    else if (sw_mem_we)
      dmem[avs_address[DMEM_AW-1:0]] <= wr_val[DATA_W-1:0];
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_ADDC_SUM: assert property (fire_q3 && is_add_c |=>
    result == DATA_W'(wreg + opnd + {7'h00, status[ST_C]}))
    else $error("carry add sum wrong");
  AST_LIT_OPND: assert property (fire_q2 && is_and_lit |=> opnd == lit)
    else $error("literal operand not taken");
  AST_LIT_W: assert property (fire_q4 && is_and_lit |=>
    wreg == ($past(wreg) & lit))
    else $error("literal and result wrong");
  AST_AND_FLAGS: assert property (fire_q4 && (is_and_lit || is_and_file) |=>
    ((status & ~ST_MASK_NZ) == ($past(status) & ~ST_MASK_NZ))
    && (status[ST_Z] == ($past(result) == 8'h00)))
    else $error("and flags wrong");
  AST_FILE_OPND: assert property (fire_q2 && is_and_file |=> opnd == dmem[opaddr])
    else $error("file operand not read");
  AST_DEST_W: assert property (fire_q4 && is_and_file && !d_bit |=>
    wreg == ($past(wreg) & opnd))
    else $error("d=0 result not in w");
  AST_DEST_F: assert property (fire_q4 && is_and_file && d_bit |->
    mem_we && (result == (wreg & opnd)) && !core_w_we)
    else $error("d=1 result not to file");
  AST_BANK: assert property (fire_q1 && is_file && a_bit |=> opaddr == {bank_select_reg, lit})
    else $error("bank address wrong");
  AST_INDEXED: assert property (fire_q1 && is_file && !a_bit && ext_en
    && (lit <= IDX_LIMIT) |=> opaddr == DMEM_AW'(idx_base + {4'h0, lit}))
    else $error("indexed address wrong");
  AST_BR_CS: assert property (fire_q3 && is_br_cs |=> br_take == status[ST_C])
    else $error("carry-set branch decision wrong");
  AST_BR_CC: assert property (fire_q3 && is_br_cc |=> br_take != status[ST_C])
    else $error("carry-clear branch decision wrong");
  AST_BR_NC: assert property (fire_q3 && is_br_nc |=> br_take != status[ST_N])
    else $error("negative-clear branch decision wrong");
  AST_BR_NS: assert property (fire_q3 && is_br_ns |=> br_take == status[ST_N])
    else $error("negative-set branch decision wrong");
  AST_BR_TARGET: assert property (fire_q4 && br_take |=>
    (pc == PC_W'($past(pc) + off2)) && $stable(status))
    else $error("branch target or flags wrong");
  AST_BR_NOP: assert property (fire_q4 && br_take |=>
    (state == S_NOP)[*8] ##1 (state == S_IDLE) && !core_busy)
    else $error("taken branch nop cycle wrong");
  AST_BR_SKIP: assert property (fire_q4 && is_br && !br_take |=>
    $stable(pc) && (state == S_IDLE))
    else $error("untaken branch not single cycle");
  AST_BCLR: assert property (fire_q4 && is_bit_clr |->
    mem_we && (result[bidx] == 1'b0) && ((result | (8'h01 << bidx)) == (opnd | (8'h01 << bidx))))
    else $error("bit clear wrong");
  AST_QUARTERS: assert property (fire_q1 |=>
    (state == S_Q2)[*2] ##1 (state == S_Q3)[*2] ##1 (state == S_Q4))
    else $error("quarter sequence wrong");
  AST_BCLR_SEQ: assert property (fire_q4 && is_bit_clr |=>
    $stable(status) && $stable(pc))
    else $error("bit clear touched flags or pc");

  COV_LIT: cover property (fire_q4 && is_and_lit);
  COV_BR_TAKEN: cover property (fire_q4 && br_take);
  COV_BR_SKIP: cover property (fire_q4 && is_br && !br_take);
  COV_BCLR: cover property (fire_q4 && is_bit_clr && ext_en);
  COV_ADDC: cover property (fire_q4 && is_add_c && d_bit);
endmodule : cbx_exec
`default_nettype wire

/* hw/cbx_pkg.sv */
package cbx_pkg;
  localparam int AV_AW   = 13;
  localparam int AV_DW   = 32;
  localparam int AV_BEW  = 4;
  localparam int DATA_W  = 8;
  localparam int IR_W    = 16;
  localparam int PC_W    = 21;
  localparam int BSR_W   = 4;
  localparam int DMEM_AW = 12;
  localparam int ST_W    = 5;

  // register word addresses; data memory window when DMEM_SEL_BIT is set
  localparam logic [AV_AW-1:0] REG_CTRL   = 13'h0000;
  localparam logic [AV_AW-1:0] REG_INSTR  = 13'h0001;
  localparam logic [AV_AW-1:0] REG_WREG   = 13'h0002;
  localparam logic [AV_AW-1:0] REG_STATUS = 13'h0003;
  localparam logic [AV_AW-1:0] REG_BANK   = 13'h0004;
  localparam logic [AV_AW-1:0] REG_PC     = 13'h0005;
  localparam logic [AV_AW-1:0] REG_IDX    = 13'h0006;
  localparam logic [AV_AW-1:0] REG_CORE   = 13'h0007;
  localparam int DMEM_SEL_BIT = 12;

  localparam int CTRL_EXT   = 0;
  localparam int CORE_BUSY  = 0;
  localparam int CORE_TAKEN = 1;
  localparam int CORE_ILL   = 2;

  // status flag positions
  localparam int ST_C  = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z  = 2;
  localparam int ST_OV = 3;
  localparam int ST_N  = 4;
  localparam logic [ST_W-1:0] ST_MASK_ALL = 5'h1F;
  localparam logic [ST_W-1:0] ST_MASK_NZ  = 5'h14;

  localparam logic [DATA_W-1:0]  W_RST   = 8'h00;
  localparam logic [ST_W-1:0]    ST_RST  = 5'h00;
  localparam logic [BSR_W-1:0]   BSR_RST = 4'h0;
  localparam logic [DMEM_AW-1:0] IDX_RST = 12'h000;
  localparam logic [IR_W-1:0]    IR_RST  = 16'h0000;
  localparam logic [PC_W-1:0]    PC_RST  = 21'h000000;
  localparam logic [PC_W-1:0]    PC_STEP = 21'h000002;

  // instruction fields
  localparam int OPC8_LSB = 8;
  localparam int OPC6_LSB = 10;
  localparam int OPC4_LSB = 12;
  localparam int IR_D     = 9;
  localparam int IR_A     = 8;
  localparam int IR_B_LSB = 9;
  localparam logic [7:0] OP_AND_LIT  = 8'h0B;
  localparam logic [5:0] OP_AND_FILE = 6'h05;
  localparam logic [5:0] OP_ADD_C    = 6'h08;
  localparam logic [3:0] OP_BIT_CLR  = 4'h9;
  localparam logic [7:0] OP_BR_CS    = 8'hE2;
  localparam logic [7:0] OP_BR_CC    = 8'hE3;
  localparam logic [7:0] OP_BR_NS    = 8'hE6;
  localparam logic [7:0] OP_BR_NC    = 8'hE7;

  localparam logic [DATA_W-1:0] IDX_LIMIT    = 8'h5F;
  localparam logic [DATA_W-1:0] ACCESS_SPLIT = 8'h60;
  localparam logic [BSR_W-1:0]  ACCESS_HI    = 4'hF;

  localparam int QUARTER_CYCLES = 2;
  localparam logic [1:0] QDIV_LAST = 2'h1;
  localparam logic [1:0] NOP_LAST  = 2'h3;

  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_Q1   = 6'b000010,
    S_Q2   = 6'b000100,
    S_Q3   = 6'b001000,
    S_Q4   = 6'b010000,
    S_NOP  = 6'b100000
  } cbx_state_e;

  typedef enum logic [1:0] {
    ALU_ADDC = 2'h0,
    ALU_AND  = 2'h1,
    ALU_BCLR = 2'h2
  } cbx_alu_e;
endpackage : cbx_pkg

/* hw/cbx_alu.sv */
`timescale 1ns/1ps
`default_nettype none
module cbx_alu (
  input  wire cbx_pkg::cbx_alu_e         op,
  input  wire logic [cbx_pkg::DATA_W-1:0] w,
  input  wire logic [cbx_pkg::DATA_W-1:0] f,
  input  wire logic                       c,
  input  wire logic [2:0]                 bit_idx,
  output var  logic [cbx_pkg::DATA_W-1:0] res,
  output var  logic [cbx_pkg::ST_W-1:0]   flags
);
  import cbx_pkg::*;

  logic [DATA_W:0] sum;
  logic [4:0]      half;

  always_comb
  begin
    sum   = {1'b0, w} + {1'b0, f} + {8'h00, c};
    half  = {1'b0, w[3:0]} + {1'b0, f[3:0]} + {4'h0, c};
    flags = '0;
    unique case (op)
      ALU_ADDC:
      begin
        res            = sum[DATA_W-1:0];
        flags[ST_C]    = sum[DATA_W];
        flags[ST_DC]   = half[4];
        flags[ST_OV]   = (w[7] == f[7]) && (sum[7] != w[7]);
      end
      ALU_AND:  res = w & f;
      ALU_BCLR: res = f & ~(8'h01 << bit_idx);
      default:  res = f;
    endcase
    flags[ST_Z] = (res == 8'h00);
    flags[ST_N] = res[7];
  end
endmodule : cbx_alu
`default_nettype wire

/* hw/cbx_addr.sv */
`timescale 1ns/1ps
`default_nettype none
module cbx_addr (
  input  wire logic [cbx_pkg::DATA_W-1:0]  fadr,
  input  wire logic                        a_bit,
  input  wire logic                        ext_en,
  input  wire logic [cbx_pkg::BSR_W-1:0]   bank_select_reg,
  input  wire logic [cbx_pkg::DMEM_AW-1:0] idx_base,
  output var  logic [cbx_pkg::DMEM_AW-1:0] eff_addr
);
  import cbx_pkg::*;

  always_comb
  begin
    if (a_bit)
      eff_addr = {bank_select_reg, fadr};
    else if (ext_en && (fadr <= IDX_LIMIT))
      eff_addr = DMEM_AW'(idx_base + {4'h0, fadr});
    else if (fadr < ACCESS_SPLIT)
      eff_addr = {4'h0, fadr};
    else
      eff_addr = {ACCESS_HI, fadr};
  end
endmodule : cbx_addr
`default_nettype wire

/* tb/cbx_exec_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("Error %0t: got %h exp %h", $time, (got), (exp)); \
    end \
  end
module cbx_exec_tb;
  import cbx_pkg::*;
  logic                 sys_clk;
  logic                 rst;
  logic [AV_AW-1:0]     avs_address;
  logic                 avs_read;
  logic                 avs_write;
  logic [AV_DW-1:0]     avs_writedata;
  logic [AV_BEW-1:0]    avs_byteenable;
  logic [AV_DW-1:0]     avs_readdata;
  logic                 avs_waitrequest;
  logic                 core_busy;
  int                   error_cnt;
  int                   n_tests;
  int                   cyc_cnt;
  int                   i;
  int                   j;
  int                   cyc;
  logic [AV_DW-1:0]     exp_q[$];
  logic [AV_DW-1:0]     e;
  logic [7:0]           w;
  logic [7:0]           k;
  logic [7:0]           fv;
  logic [7:0]           r;
  logic [8:0]           sum;
  logic [ST_W-1:0]      st;
  logic [ST_W-1:0]      es;
  logic [PC_W-1:0]      pc;
  logic                 tk;
  logic                 d;
  logic                 a;
  logic [DMEM_AW-1:0]   t_eff[6] = '{12'h020, 12'hF80, 12'h533, 12'h35F, 12'hF60, 12'h710};
  logic [7:0]           b_op[4] = '{OP_BR_CS, OP_BR_CC, OP_BR_NS, OP_BR_NC};

  cbx_exec u_cbx_exec (
    .sys_clk         (sys_clk),
    .rst             (rst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .core_busy       (core_busy)
  );

  always #10 sys_clk = ~sys_clk;

  task automatic final_report();
    $display("TB: tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  // one avalon transfer, held until waitrequest is sampled low
  task automatic xfer(input logic wr_en, input logic [AV_AW-1:0] adr,
                      input logic [AV_DW-1:0] dat, input logic [AV_BEW-1:0] be);
    @(posedge sys_clk);
    avs_address    <= adr;
    avs_writedata  <= dat;
    avs_byteenable <= be;
    avs_write      <= wr_en;
    avs_read       <= !wr_en;
    do
      @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [AV_AW-1:0] adr, input logic [AV_DW-1:0] dat);
    xfer(1'b1, adr, dat, 4'hF);
  endtask : wr

  task automatic rd(input logic [AV_AW-1:0] adr, input logic [AV_DW-1:0] exp);
    exp_q.push_back(exp);
    xfer(1'b0, adr, 32'h0000_0000, 4'hF);
  endtask : rd

  task automatic run(input logic [IR_W-1:0] ins, output int n);
    wr(REG_INSTR, {16'h0000, ins});
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (core_busy !== 1'b0 && n < 100);
    `CHK(core_busy, 1'b0)
  endtask : run

  function automatic logic [ST_W-1:0] nzf(input logic [ST_W-1:0] s, input logic [7:0] v);
    nzf       = s;
    nzf[ST_N] = v[7];
    nzf[ST_Z] = (v == 8'h00);
  endfunction : nzf

  // read answers and write acceptance
  always @(posedge sys_clk)
  begin
    cyc_cnt++;
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
    begin
      e = exp_q.pop_front();
      `CHK(avs_readdata, e)
    end
    if (avs_write === 1'b1 && avs_waitrequest === 1'b0)
      `CHK(core_busy, 1'b0)
    if (cyc_cnt == 30000)
    begin
      error_cnt++;
      $display("Error %0t: timeout", $time);
      final_report();
    end
  end

  initial
  begin
    sys_clk = 1'b0;
    rst = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = '0;
    error_cnt = 0;
    n_tests = 0;
    cyc_cnt = 0;
    void'($urandom(10));
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    for (i = 0; i < 9; i++)
      rd(13'(i), 32'h0000_0000);
    wr(13'h0008, 32'hFFFF_FFFF);
    rd(13'h0008, 32'h0000_0000);
    wr(REG_PC, 32'h0000_0101);
    rd(REG_PC, 32'h0000_0100);
    $display("TB: reset and map done");
    for (i = 0; i < 4; i++)
    begin
      w = 8'($urandom);
      k = (i == 0) ? 8'h00 : 8'($urandom);
      st = 5'($urandom);
      pc = 21'($urandom) & 21'h0FFFFE;
      wr(REG_WREG, 32'(w));
      wr(REG_STATUS, 32'(st));
      wr(REG_PC, 32'(pc));
      run({OP_AND_LIT, k}, cyc);
      rd(REG_WREG, 32'(w & k));
      rd(REG_STATUS, 32'(nzf(st, w & k)));
      rd(REG_PC, 32'(PC_W'(pc + PC_STEP)));
    end
    $display("TB: literal and done");
    // op 0 and d0, 1 and d1, 2 bit clear, 3 addc d1, 4 addc d0, 5 and d1
    for (i = 0; i < 6; i++)
    begin
      w = 8'($urandom);
      fv = 8'($urandom);
      st = 5'($urandom);
      k = 8'($urandom);
      pc = 21'($urandom) & 21'h0FFFFE;
      d = (i == 1 || i == 3 || i == 5);
      a = (i == 2 || i == 5);
      wr(REG_CTRL, 32'(i >= 2));
      wr(REG_BANK, 32'(a ? t_eff[i][11:8] : 4'h9));
      wr(REG_IDX, 32'h0000_0300);
      wr({1'b1, t_eff[i]}, 32'(fv));
      wr(REG_WREG, 32'(w));
      wr(REG_STATUS, 32'(st));
      wr(REG_PC, 32'(pc));
      es = st;
      if (i == 2)
      begin
        d = 1'b1;
        r = fv & ~(8'h01 << k[2:0]);
        run({OP_BIT_CLR, k[2:0], a, t_eff[i][7:0]}, cyc);
      end
      else if (i == 3 || i == 4)
      begin
        sum = w + fv + st[ST_C];
        r = sum[7:0];
        es = nzf(st, r);
        es[ST_C] = sum[8];
        es[ST_DC] = (5'(w[3:0]) + 5'(fv[3:0]) + 5'(st[ST_C])) > 5'h0F;
        es[ST_OV] = (w[7] == fv[7]) && (r[7] != w[7]);
        run({OP_ADD_C, d, a, t_eff[i][7:0]}, cyc);
      end
      else
      begin
        r = w & fv;
        es = nzf(st, r);
        run({OP_AND_FILE, d, a, t_eff[i][7:0]}, cyc);
      end
      rd(REG_WREG, 32'(d ? w : r));
      rd({1'b1, t_eff[i]}, 32'(d ? r : fv));
      rd(REG_STATUS, 32'(es));
      rd(REG_PC, 32'(PC_W'(pc + PC_STEP)));
    end
    $display("TB: file ops done");
    for (j = 0; j < 8; j++)
    begin
      st = 5'($urandom);
      st[(j < 4) ? ST_C : ST_N] = j[0];
      tk = (j[0] == !j[1]);
      k = (j == 1) ? 8'h80 : 8'($urandom);
      pc = 21'($urandom) & 21'h0FFFFE;
      wr(REG_STATUS, 32'(st));
      wr(REG_PC, 32'(pc));
      run({b_op[j / 2], k}, cyc);
      pc = PC_W'(pc + PC_STEP + (tk ? {{12{k[7]}}, k, 1'b0} : 21'h0));
      rd(REG_PC, 32'(pc));
      rd(REG_STATUS, 32'(st));
      rd(REG_CORE, {30'h0, tk, 1'b0});
      `CHK(tk ? (cyc >= 15) : (cyc <= 12), 1'b1)
    end
    $display("TB: branches done");
    wr(REG_STATUS, 32'h0000_0001);
    wr(REG_INSTR, {16'h0000, OP_BR_CS, 8'h7F});
    wr(REG_WREG, 32'h0000_005A);
    rd(REG_WREG, 32'h0000_005A);
    xfer(1'b1, REG_WREG, 32'h0000_00FF, 4'h0);
    rd(REG_WREG, 32'h0000_005A);
    wr(REG_PC, 32'h0000_0040);
    run(16'hFFFF, cyc);
    rd(REG_CORE, 32'h0000_0004);
    rd(REG_PC, 32'h0000_0042);
    $display("TB: stall and refusal done");
    repeat (2) @(posedge sys_clk);
    final_report();
  end
endmodule : cbx_exec_tb
`default_nettype wire
